// ---- bench/mem_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// memory device side: measures each cycle's strobe length
module mem_partner
(
   input wire logic clk, // processor clock
   input wire logic arst_n, // async reset, active low
   input wire logic mem_cycle, // cycle strobe from the block
   output logic [3:0] run_len_q // clocks in the latest cycle
);
   logic cyc_q;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cyc_q <= 1'b0;
         run_len_q <= 4'h0;
      end
      else
      begin
         cyc_q <= mem_cycle;
         if (mem_cycle)
         begin
            run_len_q <= cyc_q ? run_len_q + 4'h1 : 4'h1;
         end
      end
   end
endmodule : mem_partner
`default_nettype wire

// ---- bench/memory_wait_state_timing_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module memory_wait_state_timing_test
   import mem_timing_pkg::*;
;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata, rd;
   logic pready, pslverr, req_rdy, mem_cycle, mem_done, ref_req, err;
   logic ref_pin = 1'b0;
   mem_req_s mem_req = '0;
   region_e mem_region;
   logic [3:0] run_len;
   logic [9:0] ex;
   logic [9:0] exp_q[$];
   int tk_q[$];
   int fails = 0;
   int checked = 0;
   int cyc = 0;
   int refs = 0;
   int n0;
   always #2.5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   always @(posedge clk) if (ref_req === 1'b1) refs <= refs + 1;
   mem_wait_timing mem_wait_timing_i (.clk(clk), .arst_n(arst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mem_req(mem_req), .mem_req_ready(req_rdy),
      .mem_cycle(mem_cycle), .mem_region(mem_region),
      .mem_done(mem_done), .ref_clk_pin(ref_pin), .refresh_req(ref_req));
   mem_partner mem_partner_i (.clk(clk), .arst_n(arst_n),
      .mem_cycle(mem_cycle), .run_len_q(run_len));
   // ==========================================================
   // shared tasks
   task automatic cmp(input string what, input logic [31:0] e,
      input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask : cmp
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic mem_run(input logic [2:0] code, input logic sh,
      input logic lo);
      region_e rg;
      logic [3:0] len;
      rg = region_e'($urandom % 3);
      if (sh && code == 3'h0)
         rg = REGION_ROM_A;
      len = (sh ? 4'h3 : 4'h5) + {1'b0, code};
      apb(1'b1, RAM_TIMING_ADDR, {24'h0, sh, code, 3'h0, lo});
      apb(1'b1, ROM_TIMING_ADDR, {25'h0, code, 1'b0, code});
      @(posedge clk);
      mem_req <= '{valid: 1'b1, region: rg};
      @(posedge clk);
      while (req_rdy !== 1'b1)
         @(posedge clk);
      exp_q.push_back({rg, len, len + 4'h1 + {3'h0, lo}});
      tk_q.push_back(cyc);
      mem_req <= '0;
   endtask : mem_run
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test
   // ==========================================================
   // monitor of completed memory cycles
   always @(posedge clk)
   begin
      if (mem_done === 1'b1)
      begin
         if (exp_q.size() == 0)
            cmp("done without request", 32'h0, 32'h1);
         else
         begin
            ex = exp_q.pop_front();
            cmp("region", {30'h0, ex[9:8]}, {30'h0, mem_region});
            cmp("cycle length", {28'h0, ex[7:4]}, {28'h0, run_len});
            cmp("latency", {28'h0, ex[3:0]}, cyc - tk_q.pop_front());
         end
      end
   end
   // ==========================================================
   // main sequence
   initial
   begin
      void'($urandom(32'h4F77512A));
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      apb(1'b0, ROM_TIMING_ADDR, 32'h0);
      cmp("rom reset", 32'h77, rd);
      apb(1'b0, RAM_TIMING_ADDR, 32'h0);
      cmp("ram reset", 32'h71, rd);
      apb(1'b0, REFRESH_ADDR, 32'h0);
      cmp("refresh reset", 32'h0, rd);
      apb(1'b0, 12'h000, 32'h0);
      cmp("unmapped error", 32'h1, {31'h0, err});
      apb(1'b1, RAM_TIMING_ADDR, 32'hFF);
      apb(1'b0, RAM_TIMING_ADDR, 32'h0);
      cmp("ram reserved", 32'hF1, rd);
      pstrb <= 4'h0;
      apb(1'b1, ROM_TIMING_ADDR, 32'h0);
      pstrb <= 4'hF;
      apb(1'b0, ROM_TIMING_ADDR, 32'h0);
      cmp("rom strobe", 32'h77, rd);
      $display("test registers done");
      for (int k = 0; k < 32; k++)
         mem_run(k[2:0], k[3], k[4]);
      repeat (30) @(posedge clk);
      cmp("pending cycles", 32'h0, exp_q.size());
      apb(1'b1, STATUS_ADDR, 32'hFF);
      cmp("status write error", 32'h0, {31'h0, err});
      apb(1'b0, STATUS_ADDR, 32'h0);
      cmp("status idle", 32'h0A, rd);
      $display("test cycles done");
      for (int i = 0; i < 2; i++)
      begin
         apb(1'b1, REFRESH_ADDR, i ? 32'hFD : 32'h00);
         n0 = refs;
         repeat (4)
         begin
            repeat (10) @(posedge clk);
            ref_pin <= ~ref_pin;
         end
         repeat (10) @(posedge clk);
         cmp("refresh count", i ? 32'h2 : 32'h4, refs - n0);
      end
      $display("test refresh done");
      end_of_test;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      end_of_test;
   end
endmodule : memory_wait_state_timing_test
`default_nettype wire

// ---- logic/mem_timing_pkg.sv ----
// Function
// - rom_b_wait_code is bits 6:4 of rom_cycle_timing, reset to 111.
// - a wait code of 0..7 adds that many clocks to the minimum cycle.
// - with short_cycle_select clear, codes 0..7 give 5..12 clocks.
// - with short_cycle_select set, codes 0..7 give 3..10 clocks.
// - rom_a_wait_code is bits 2:0, reset to 111, decoded like rom_b.
// - bit 7 of ram_cycle_timing (index 7DH) selects the short cycle.
// - the RAM wait code is bits 6:4 of ram_cycle_timing, reset to 111.
// - bit 0 of ram_cycle_timing is leadoff_delay_enable, reset to 1.
// - with leadoff delay on, each cycle starts one clock later.
// - reserved timing register bits reset to zero.
// - refresh_interval_code divides the 32.768 kHz clock; 00H = each edge.
`default_nettype none
package mem_timing_pkg;
   // ==========================================================
   // register map (byte address is four times the index)
   localparam logic [7:0] ROM_TIMING_IDX = 8'h7C;
   localparam logic [7:0] RAM_TIMING_IDX = 8'h7D;
   localparam logic [7:0] REFRESH_IDX = 8'h7E;
   localparam logic [7:0] STATUS_IDX = 8'h7F;
   localparam logic [11:0] ROM_TIMING_ADDR = {2'h0, ROM_TIMING_IDX, 2'h0};
   localparam logic [11:0] RAM_TIMING_ADDR = {2'h0, RAM_TIMING_IDX, 2'h0};
   localparam logic [11:0] REFRESH_ADDR = {2'h0, REFRESH_IDX, 2'h0};
   localparam logic [11:0] STATUS_ADDR = {2'h0, STATUS_IDX, 2'h0};
   // ==========================================================
   // field positions
   localparam int ROM_B_WAIT_LSB = 4;
   localparam int ROM_A_WAIT_LSB = 0;
   localparam int RAM_WAIT_LSB = 4;
   localparam int SHORT_CYCLE_BIT = 7;
   localparam int LEADOFF_BIT = 0;
   localparam int STAT_BUSY_BIT = 7;
   localparam int STAT_LEADOFF_BIT = 6;
   // ==========================================================
   // reset values and writable bits
   localparam logic [7:0] ROM_TIMING_RST = 8'h77;
   localparam logic [7:0] RAM_TIMING_RST = 8'h71;
   localparam logic [7:0] REFRESH_RST = 8'h00;
   localparam logic [7:0] ROM_WR_MASK = 8'h77;
   localparam logic [7:0] RAM_WR_MASK = 8'hF1;
   // ==========================================================
   // timing counts in processor clocks and slow clock edges
   localparam logic [3:0] SLOW_MIN_CLKS = 4'h5;
   localparam logic [3:0] SHORT_MIN_CLKS = 4'h3;
   localparam logic [8:0] REF_EDGES_ALL = 9'h100;
   localparam logic [8:0] REF_EDGES_BASE = 9'h0FF;
   localparam logic [7:0] REF_CODE_ALL = 8'hFF;
   // ==========================================================
   // types
   typedef enum logic [1:0] {
      REGION_ROM_A = 2'h0,
      REGION_ROM_B = 2'h1,
      REGION_RAM = 2'h2
   } region_e;
   typedef struct packed {
      logic valid;
      region_e region;
   } mem_req_s;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LEADOFF = 3'b010,
      ST_ACTIVE = 3'b100
   } cyc_state_e;
endpackage : mem_timing_pkg
`default_nettype wire

// ---- logic/mem_wait_timing.sv ----
`timescale 1ns/1ps
`default_nettype none
module mem_wait_timing
   import mem_timing_pkg::*;
(
   input wire logic clk, // processor_clock, 200 MHz
   input wire logic arst_n, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [3:0] pstrb, // apb byte strobes
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire mem_req_s mem_req, // processor access request
   output logic mem_req_ready, // access may be taken
   output logic mem_cycle, // memory cycle in progress
   output region_e mem_region, // region of current cycle
   output logic mem_done, // access completed, one pulse
   input wire logic ref_clk_pin, // 32.768 kHz pin
   output logic refresh_req // refresh request, one pulse
);
   // ==========================================================
   // decode helpers
   function automatic logic [3:0] cycle_clocks(
      input logic [2:0] code,
      input logic short_sel
   );
      cycle_clocks = (short_sel ? SHORT_MIN_CLKS : SLOW_MIN_CLKS) +
         {1'b0, code};
   endfunction : cycle_clocks

   function automatic logic [8:0] ref_edges(input logic [7:0] code);
      if (code == REFRESH_RST)
      begin
         ref_edges = 9'h001;
      end
      else if (code == REF_CODE_ALL)
      begin
         ref_edges = REF_EDGES_ALL;
      end
      else
      begin
         ref_edges = REF_EDGES_BASE - {1'b0, code};
      end
   endfunction : ref_edges

   // ==========================================================
   // registers
   logic [7:0] rom_q;
   logic [7:0] ram_q;
   logic [7:0] refresh_q;
   logic [7:0] prdata_q;
   logic [7:0] status;
   logic sel_rom;
   logic sel_ram;
   logic sel_ref;
   logic sel_stat;
   logic mapped;
   logic wr_en;
   logic [7:0] wbyte;

   assign sel_rom = (paddr == ROM_TIMING_ADDR);
   assign sel_ram = (paddr == RAM_TIMING_ADDR);
   assign sel_ref = (paddr == REFRESH_ADDR);
   assign sel_stat = (paddr == STATUS_ADDR);
   assign mapped = sel_rom | sel_ram | sel_ref | sel_stat;
   assign wr_en = psel & penable & pwrite & pstrb[0];
   assign wbyte = pwdata[7:0];
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = {24'h000000, prdata_q};

   // timing registers; reserved bits never store
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rom_q <= ROM_TIMING_RST;
         ram_q <= RAM_TIMING_RST;
      end
      else if (wr_en && sel_rom)
      begin
         rom_q <= wbyte & ROM_WR_MASK;
      end
      else if (wr_en && sel_ram)
      begin
         ram_q <= wbyte & RAM_WR_MASK;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         refresh_q <= REFRESH_RST;
      end
      else if (wr_en && sel_ref)
      begin
         refresh_q <= wbyte;
      end
   end

   // read data latched in the setup phase
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         prdata_q <= 8'h00;
      end
      else if (psel && !penable)
      begin
         if (sel_rom)
         begin
            prdata_q <= rom_q;
         end
         else if (sel_ram)
         begin
            prdata_q <= ram_q;
         end
         else if (sel_ref)
         begin
            prdata_q <= refresh_q;
         end
         else if (sel_stat)
         begin
            prdata_q <= status;
         end
         else
         begin
            prdata_q <= 8'h00;
         end
      end
   end

   // ==========================================================
   // memory cycle sequencer
   cyc_state_e state_q;
   logic [3:0] len_q;
   logic [3:0] remain_q;
   logic done_q;
   region_e region_q;
   logic [2:0] sel_code;
   logic short_sel;
   logic leadoff_on;
   logic accept;

   assign short_sel = ram_q[SHORT_CYCLE_BIT];
   assign leadoff_on = ram_q[LEADOFF_BIT];
   assign mem_req_ready = (state_q == ST_IDLE);
   assign accept = mem_req.valid & mem_req_ready;
   assign mem_cycle = (state_q == ST_ACTIVE);
   assign mem_region = region_q;
   assign mem_done = done_q;
   assign status = {mem_cycle | (state_q == ST_LEADOFF),
      state_q == ST_LEADOFF, 2'h0, len_q};

   always_comb
   begin
      case (mem_req.region)
         REGION_ROM_A: sel_code = rom_q[ROM_A_WAIT_LSB +: 3];
         REGION_ROM_B: sel_code = rom_q[ROM_B_WAIT_LSB +: 3];
         default: sel_code = ram_q[RAM_WAIT_LSB +: 3];
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= ST_IDLE;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (accept)
               begin
                  state_q <= leadoff_on ? ST_LEADOFF : ST_ACTIVE;
               end
            end
            ST_LEADOFF:
            begin
               state_q <= ST_ACTIVE;
            end
            ST_ACTIVE:
            begin
               if (remain_q == 4'h0)
               begin
                  state_q <= ST_IDLE;
               end
            end
            default:
            begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // length latched at acceptance, counted down while active
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         len_q <= 4'h0;
         remain_q <= 4'h0;
         region_q <= REGION_ROM_A;
      end
      else if (accept)
      begin
         len_q <= cycle_clocks(sel_code, short_sel);
         remain_q <= cycle_clocks(sel_code, short_sel) - 4'h1;
         region_q <= mem_req.region;
      end
      else if (mem_cycle && remain_q != 4'h0)
      begin
         remain_q <= remain_q - 4'h1;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= mem_cycle && (remain_q == 4'h0);
      end
   end

   // ==========================================================
   // refresh divider on the 32.768 kHz pin
   logic [2:0] ref_s_q;
   logic ref_edge;
   logic [8:0] ref_cnt_q;
   logic ref_q;

   assign ref_edge = ref_s_q[1] ^ ref_s_q[2];
   assign refresh_req = ref_q;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ref_s_q <= 3'h0;
      end
      else
      begin
         ref_s_q <= {ref_s_q[1:0], ref_clk_pin};
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ref_cnt_q <= 9'h000;
         ref_q <= 1'b0;
      end
      else if (wr_en && sel_ref)
      begin
         ref_cnt_q <= ref_edges(wbyte) - 9'h001;
         ref_q <= 1'b0;
      end
      else if (ref_edge && ref_cnt_q == 9'h000)
      begin
         ref_cnt_q <= ref_edges(refresh_q) - 9'h001;
         ref_q <= 1'b1;
      end
      else
      begin
         ref_cnt_q <= ref_edge ? ref_cnt_q - 9'h001 : ref_cnt_q;
         ref_q <= 1'b0;
      end
   end

   // ==========================================================
   // assertions
   logic [3:0] act_cnt_q;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         act_cnt_q <= 4'h0;
      end
      else
      begin
         act_cnt_q <= mem_cycle ? act_cnt_q + 4'h1 : 4'h0;
      end
   end

   sequence s_take_slow0;
      accept && !short_sel && !leadoff_on && sel_code == 3'h0;
   endsequence

   sequence s_take_fast5_lead;
      accept && short_sel && leadoff_on && sel_code == 3'h5;
   endsequence

   sequence s_cycle_end;
      !mem_cycle && mem_done ##1 !mem_done;
   endsequence

   a_slow_minimum: assert property (
      @(posedge clk) disable iff (!arst_n)
      s_take_slow0 |=> mem_cycle [*5] ##1 s_cycle_end)
      else $error("slow code 0 cycle not 5 clocks");

   a_fast_leadoff: assert property (
      @(posedge clk) disable iff (!arst_n)
      s_take_fast5_lead |=> !mem_cycle ##1 mem_cycle [*8] ##1 !mem_cycle)
      else $error("short code 5 with leadoff not 1+8 clocks");

   a_no_leadoff: assert property (
      @(posedge clk) disable iff (!arst_n)
      accept && !leadoff_on |=> mem_cycle)
      else $error("cycle delayed without leadoff");

   a_cycle_length: assert property (
      @(posedge clk) disable iff (!arst_n)
      $fell(mem_cycle) |-> $past(act_cnt_q) + 4'h1 == len_q)
      else $error("active cycle length differs from latched");

   a_length_range: assert property (
      @(posedge clk) disable iff (!arst_n)
      accept |=> len_q == ($past(short_sel) ? 4'h3 : 4'h5) +
         {1'b0, $past(sel_code)})
      else $error("cycle length decode wrong");

   a_done_hold: assert property (
      @(posedge clk) disable iff (!arst_n)
      mem_cycle |-> !mem_req_ready && !mem_done)
      else $error("access released during cycle");

   a_reset_values: assert property (
      @(posedge clk) disable iff (!arst_n)
      !$past(arst_n) |-> rom_q == 8'h77 && ram_q == 8'h71)
      else $error("timing register reset value wrong");

   a_ram_write: assert property (
      @(posedge clk) disable iff (!arst_n)
      wr_en && sel_ram |=> ram_q == ($past(wbyte) & 8'hF1))
      else $error("ram timing write not stored");

   a_refresh_each: assert property (
      @(posedge clk) disable iff (!arst_n)
      ref_edge && refresh_q == 8'h00 && !(wr_en && sel_ref)
      |=> refresh_req ##1 !refresh_req)
      else $error("divisor 00H missed a refresh");

endmodule : mem_wait_timing
`default_nettype wire
